// file: hdl/unx_regs.svh
// Register offsets, field positions and reset values of the network UART extension
`ifndef UNX_REGS_SVH
`define UNX_REGS_SVH

`define UNX_OFF_MODEM 32'hFFFF0718
`define UNX_OFF_SCRATCH 32'hFFFF071C
`define UNX_OFF_NETCTL 32'hFFFF0720
`define UNX_OFF_IRQID 32'hFFFF0724
`define UNX_OFF_NODEADR 32'hFFFF0728
`define UNX_OFF_FRACDIV 32'hFFFF072C

`define UNX_RST_MODEM 8'h00
`define UNX_RST_SCRATCH 8'h00
`define UNX_RST_NETCTL 8'h04
`define UNX_RST_IRQID 8'h01
`define UNX_RST_NODEADR 8'hAA
`define UNX_RST_FRACDIV 16'h0000

`define UNX_NC_MODE 7
`define UNX_NC_TX9 6
`define UNX_NC_RX9 5
`define UNX_NC_IRQEN 4
`define UNX_NC_WORD9 3
`define UNX_NC_DRV 2
`define UNX_NC_POL 1
`define UNX_NC_ADDR 0

`define UNX_FD_EN 15
`define UNX_FD_M_HI 12
`define UNX_FD_M_LO 11
`define UNX_FD_N_HI 10
`define UNX_FD_WMASK 16'h9FFF

`define UNX_ID_MATCH 8'h0C
`define UNX_ID_ADDRTX 8'h0A
`define UNX_ID_NONE 8'h01

`define UNX_M_ZERO_AS 3'h4

`endif

// file: hdl/unx_pkg.sv
// Types shared by the network UART extension
package unx_pkg;
    typedef logic [7:0] unx_byte_t;
    typedef logic [3:0] unx_modem_t;
    typedef enum logic [1:0] {SRC_NONE, SRC_ADDR_TX, SRC_MATCH} unx_src_t;
endpackage

// file: hdl/unx_ext.sv
// Modem status, scratch, fractional divider control and network address mode
// Functional notes
// - Upper nibble shows live DCD RI DSR CTS
// - Bit 3 flags DCD change, read clears
// - Bit 2 flags RI rising, read clears
// - Bit 1 flags DSR change, read clears
// - Bit 0 flags CTS change, read clears
// - Scratch byte readable and writable, always
// - Bit 15 selects fractional baud generator
// - Bits 10:0 give fractional value N
// - Bit 7 enables network address mode
// - No parity while network mode active
// - Up to 256 nodes, single or multimaster
// - Bit 0 marks next character as address
// - Bit 1 sets address bit polarity
// - Bit 6 enables 9-bit transmit in mode
// - Bit 5 enables 9-bit receive in mode
// - Bit 4 gates network interrupt
// - Bit 3 selects 9-bit data words while bit 6 is clear
// - Bit 2 drives output pin, else released in network mode
// - Irq id upper nibble reserved, resets 0x01
// - Address match interrupts and sets status code
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "unx_regs.svh"

module unx_ext
    import unx_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Modem pins
    input wire logic dcd_pin,
    input wire logic ri_pin,
    input wire logic dsr_pin,
    input wire logic cts_pin,
    // UART core receive side
    input wire logic rx_char_valid,
    input wire logic [8:0] rx_char,
    input wire logic rx_buf_read,
    // UART core transmit side
    input wire logic tx_load,
    input wire logic tx_char_done,
    input wire logic tx_serial,
    // Serial output pin
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_n,
    // Controls to the UART core
    output logic parity_inhibit,
    output logic tx_ninth_en,
    output logic tx_ninth_bit,
    output logic rx_ninth_en,
    output logic data_word9,
    output logic frac_baud_sel,
    output logic [2:0] frac_mult,
    output logic [10:0] frac_numer,
    // Network interrupt request
    output logic net_irq
);

    // Ninth bit equal to polarity marks an address character
    function automatic logic addr_ninth(input logic is_addr, input logic pol);
        addr_ninth = is_addr ? pol : ~pol;
    endfunction

    function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
        hit = (a == off);
    endfunction

    unx_modem_t modem_meta_reg;
    unx_modem_t modem_sync_reg;
    unx_modem_t modem_prev_reg;
    unx_modem_t chg_reg;
    unx_modem_t chg_next;
    unx_modem_t chg_event;
    unx_byte_t scratch_reg;
    unx_byte_t netctl_reg;
    unx_byte_t nodeadr_reg;
    logic [15:0] fracdiv_reg;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    unx_src_t src;
    logic match_reg;
    logic addrtx_reg;
    logic tx_is_addr_reg;
    logic modem_read;
    logic mode_on;
    logic rx_addr_hit;
    logic addrtx_event;

    assign modem_read = reg_rd && hit(reg_addr, `UNX_OFF_MODEM);
    assign mode_on = netctl_reg[`UNX_NC_MODE];

    // Two flops before the pins are looked at
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            modem_meta_reg <= 4'h0;
            modem_sync_reg <= 4'h0;
            modem_prev_reg <= 4'h0;
        end
        else
        begin
            modem_meta_reg <= {dcd_pin, ri_pin, dsr_pin, cts_pin};
            modem_sync_reg <= modem_meta_reg;
            modem_prev_reg <= modem_sync_reg;
        end
    end

    always_comb
    begin
        chg_event[3] = modem_sync_reg[3] ^ modem_prev_reg[3];
        chg_event[2] = modem_sync_reg[2] & ~modem_prev_reg[2];
        chg_event[1] = modem_sync_reg[1] ^ modem_prev_reg[1];
        chg_event[0] = modem_sync_reg[0] ^ modem_prev_reg[0];
        // Set wins over the clear of a read
        chg_next = (modem_read ? 4'h0 : chg_reg) | chg_event;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            chg_reg <= 4'h0;
        else
            chg_reg <= chg_next;
    end

    // Software registers
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            scratch_reg <= `UNX_RST_SCRATCH;
            netctl_reg <= `UNX_RST_NETCTL;
            nodeadr_reg <= `UNX_RST_NODEADR;
            fracdiv_reg <= `UNX_RST_FRACDIV;
        end
        else if (reg_wr)
        begin
            if (hit(reg_addr, `UNX_OFF_SCRATCH))
                scratch_reg <= reg_wdata[7:0];
            if (hit(reg_addr, `UNX_OFF_NETCTL))
                netctl_reg <= reg_wdata[7:0];
            if (hit(reg_addr, `UNX_OFF_NODEADR))
                nodeadr_reg <= reg_wdata[7:0];
            if (hit(reg_addr, `UNX_OFF_FRACDIV))
                fracdiv_reg <= reg_wdata & `UNX_FD_WMASK;
        end
    end

    // Address reception: 8-bit node field covers 256 nodes
    assign rx_addr_hit = rx_char_valid && mode_on && netctl_reg[`UNX_NC_RX9]
        && (rx_char[8] == addr_ninth(1'b1, netctl_reg[`UNX_NC_POL]))
        && (rx_char[7:0] == nodeadr_reg);

    // Reading the receive buffer clears the match; a new match wins
    always_ff @(posedge core_clk)
    begin
        if (srst)
            match_reg <= 1'b0;
        else if (rx_addr_hit)
            match_reg <= 1'b1;
        else if (rx_buf_read)
            match_reg <= 1'b0;
    end

    // Remember whether the character in flight was an address
    always_ff @(posedge core_clk)
    begin
        if (srst)
            tx_is_addr_reg <= 1'b0;
        else if (tx_load)
            tx_is_addr_reg <= tx_ninth_en && netctl_reg[`UNX_NC_ADDR];
    end

    assign addrtx_event = tx_char_done && tx_is_addr_reg && mode_on;

    always_ff @(posedge core_clk)
    begin
        if (srst)
            addrtx_reg <= 1'b0;
        else if (addrtx_event)
            addrtx_reg <= 1'b1;
        else if (tx_load)
            addrtx_reg <= 1'b0;
    end

    always_comb
    begin
        if (match_reg)
            src = SRC_MATCH;
        else if (addrtx_reg)
            src = SRC_ADDR_TX;
        else
            src = SRC_NONE;
    end

    // Read data, valid the cycle after the strobe only
    always_comb
    begin
        rdata_next = 16'h0000;
        if (reg_rd)
        begin
            case (1'b1)
                hit(reg_addr, `UNX_OFF_MODEM):
                    rdata_next = {8'h00, modem_sync_reg, chg_reg};
                hit(reg_addr, `UNX_OFF_SCRATCH):
                    rdata_next = {8'h00, scratch_reg};
                hit(reg_addr, `UNX_OFF_NETCTL):
                    rdata_next = {8'h00, netctl_reg};
                hit(reg_addr, `UNX_OFF_IRQID):
                begin
                    case (src)
                        SRC_MATCH: rdata_next = {8'h00, `UNX_ID_MATCH};
                        SRC_ADDR_TX: rdata_next = {8'h00, `UNX_ID_ADDRTX};
                        default: rdata_next = {8'h00, `UNX_ID_NONE};
                    endcase
                end
                hit(reg_addr, `UNX_OFF_NODEADR):
                    rdata_next = {8'h00, nodeadr_reg};
                hit(reg_addr, `UNX_OFF_FRACDIV):
                    rdata_next = fracdiv_reg;
                default:
                    rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            rdata_reg <= 16'h0000;
        else
            rdata_reg <= rdata_next;
    end

    assign reg_rdata = rdata_reg;

    // Core controls, registered
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            parity_inhibit <= 1'b0;
            tx_ninth_en <= 1'b0;
            tx_ninth_bit <= 1'b0;
            rx_ninth_en <= 1'b0;
            data_word9 <= 1'b0;
            frac_baud_sel <= 1'b0;
            frac_mult <= `UNX_M_ZERO_AS;
            frac_numer <= 11'h000;
            net_irq <= 1'b0;
        end
        else
        begin
            parity_inhibit <= mode_on;
            tx_ninth_en <= mode_on && netctl_reg[`UNX_NC_TX9];
            tx_ninth_bit <= addr_ninth(netctl_reg[`UNX_NC_ADDR], netctl_reg[`UNX_NC_POL]);
            rx_ninth_en <= mode_on && netctl_reg[`UNX_NC_RX9];
            data_word9 <= netctl_reg[`UNX_NC_WORD9] && !netctl_reg[`UNX_NC_TX9];
            frac_baud_sel <= fracdiv_reg[`UNX_FD_EN];
            frac_mult <= (fracdiv_reg[`UNX_FD_M_HI:`UNX_FD_M_LO] == 2'h0) ? `UNX_M_ZERO_AS
                : {1'b0, fracdiv_reg[`UNX_FD_M_HI:`UNX_FD_M_LO]};
            frac_numer <= fracdiv_reg[`UNX_FD_N_HI:0];
            // Polarity picks the active level of the request
            net_irq <= (mode_on && netctl_reg[`UNX_NC_IRQEN] && (src != SRC_NONE))
                == netctl_reg[`UNX_NC_POL];
        end
    end

    // Pin released only in network mode with the driver off
    assign serial_out_pin_o = tx_serial;
    assign serial_out_pin_oe_n = mode_on && !netctl_reg[`UNX_NC_DRV];

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence s_modem_rd;
        reg_rd && hit(reg_addr, `UNX_OFF_MODEM);
    endsequence

    sequence s_dcd_moves;
        modem_sync_reg[3] != modem_prev_reg[3];
    endsequence

    a_keep_on_read: assert property (s_modem_rd and s_dcd_moves |=> chg_reg[3])
        else $error("DCD change lost during read");
    a_clear_on_read: assert property (s_modem_rd ##0 (chg_event == 4'h0) |=> chg_reg == 4'h0)
        else $error("Change flags not cleared by read");
    a_ri_fall_quiet: assert property ((chg_reg[2] == 1'b0) && modem_prev_reg[2] &&
        !modem_sync_reg[2] |=> !chg_reg[2])
        else $error("Ring flag set on falling edge");
    a_modem_live: assert property (s_modem_rd |=> reg_rdata[7:4] == $past(modem_sync_reg))
        else $error("Modem live bits wrong");
    a_dsr_cts_set: assert property ((chg_event[1] || chg_event[0]) |=>
        (chg_reg[1:0] & $past(chg_event[1:0])) == $past(chg_event[1:0]))
        else $error("DSR or CTS change missed");
    a_scratch_back: assert property (reg_wr && hit(reg_addr, `UNX_OFF_SCRATCH) ##1
        reg_rd && hit(reg_addr, `UNX_OFF_SCRATCH) && !reg_wr |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 2))
        else $error("Scratch readback wrong");
    a_frac_reserved: assert property (reg_rd && hit(reg_addr, `UNX_OFF_FRACDIV) |=>
        reg_rdata[14:13] == 2'h0)
        else $error("Reserved divider bits not zero");
    a_irqid_nibble: assert property (reg_rd && hit(reg_addr, `UNX_OFF_IRQID) |=>
        reg_rdata[7:4] == 4'h0 && (reg_rdata[0] == ($past(src) == SRC_NONE)))
        else $error("Irq id format wrong");
    a_match_code: assert property (rx_addr_hit |=> match_reg ##0 (src == SRC_MATCH))
        else $error("Address match not flagged");
    a_tx9_gated: assert property (!mode_on |=> !tx_ninth_en && !rx_ninth_en && !parity_inhibit)
        else $error("Nine-bit active outside mode");
    a_mult_zero: assert property (fracdiv_reg[12:11] == 2'h0 |=> frac_mult == 3'h4)
        else $error("Multiplier zero not four");
    a_frac_sel: assert property (frac_baud_sel == $past(fracdiv_reg[15], 1) || $rose(srst))
        else $error("Baud source select wrong");
    a_irq_gate: assert property (!netctl_reg[4] && netctl_reg[1] |=> !net_irq)
        else $error("Interrupt not gated");

    // Change flags and fraction N follow their sources by one cycle; scratch holds without a write
    a_dcd_set: assert property (chg_event[3] |=> chg_reg[3])
        else $error("DCD change flag not set");
    a_ring_set: assert property (chg_event[2] |=> chg_reg[2])
        else $error("Ring rise flag not set");
    a_scratch_hold: assert property (!(reg_wr && hit(reg_addr, `UNX_OFF_SCRATCH)) |=>
        $stable(scratch_reg))
        else $error("Scratch changed without a write");
    a_numer_track: assert property (frac_numer == $past(fracdiv_reg[`UNX_FD_N_HI:0]))
        else $error("Fraction N not passed on");

    // Network match and interrupt level
    a_mode_off_quiet: assert property (!mode_on && !match_reg |=> !match_reg)
        else $error("Match flagged outside network mode");
    a_ninth_mismatch: assert property (!match_reg &&
        (rx_char[8] != netctl_reg[`UNX_NC_POL]) |=> !match_reg)
        else $error("Match with wrong ninth bit");
    a_match_clear: assert property (rx_buf_read && !rx_addr_hit |=> !match_reg)
        else $error("Match not cleared by buffer read");
    a_addrtx_set: assert property (addrtx_event |=> addrtx_reg)
        else $error("Address sent not flagged");
    a_irqid_addr: assert property (addrtx_reg && !match_reg &&
        reg_rd && hit(reg_addr, `UNX_OFF_IRQID) |=> reg_rdata[7:0] == `UNX_ID_ADDRTX)
        else $error("Address sent code missing");
    a_irq_idle: assert property (src == SRC_NONE |=>
        net_irq != $past(netctl_reg[`UNX_NC_POL]))
        else $error("Idle interrupt level wrong");
    a_irq_active: assert property (mode_on && netctl_reg[`UNX_NC_IRQEN] && match_reg |=>
        net_irq == $past(netctl_reg[`UNX_NC_POL]))
        else $error("Enabled interrupt not raised");

    // Pin, word length, parity and read port
    a_drv_enable: assert property (netctl_reg[`UNX_NC_DRV] || !mode_on |-> !serial_out_pin_oe_n)
        else $error("Pin released while driver on");
    a_word9_excl: assert property (data_word9 |-> !$past(netctl_reg[`UNX_NC_TX9]))
        else $error("Nine-bit words with nine-bit transmit");
    a_parity_off: assert property (mode_on |=> parity_inhibit)
        else $error("Parity not inhibited in mode");
    a_rx9_on: assert property (mode_on && netctl_reg[`UNX_NC_RX9] |=> rx_ninth_en)
        else $error("Nine-bit receive not enabled");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("Read data outside read cycle");

endmodule
`default_nettype wire

// file: sim/unx_node_model.sv
// Remote network node model feeding received characters to the core side
`timescale 1ns/1ps
`default_nettype none

module unx_node_model
(
    // Clock
    input wire logic core_clk,
    // Bench request
    input wire logic send_req,
    input wire logic [8:0] send_char,
    // Core receive side
    output logic rx_char_valid,
    output logic [8:0] rx_char
);
    initial
    begin
        rx_char_valid = 1'b0;
        rx_char = 9'h000;
    end

    // One 9-bit character per request, ninth bit marks an address byte
    always @(posedge core_clk)
    begin
        rx_char_valid <= send_req;
        if (send_req)
            rx_char <= send_char;
        else if (rx_char_valid)
            rx_char <= ~rx_char; // Released bus must not keep the old byte
    end
endmodule

`default_nettype wire

// file: sim/uart_network_modem_ext_tb_top.sv
// Self-checking bench of the network UART extension
`timescale 1ns/1ps
`default_nettype none
`include "unx_regs.svh"

module uart_network_modem_ext_tb_top;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [31:0] reg_addr = 32'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic [15:0] reg_rdata, r1, r2, v;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rx_buf_read = 1'b0, tx_load = 1'b0, tx_char_done = 1'b0;
    logic tx_serial = 1'b0, send_req = 1'b0;
    logic dcd_pin = 1'b0, ri_pin = 1'b0, dsr_pin = 1'b0, cts_pin = 1'b0;
    logic rx_char_valid, serial_out_pin_o, serial_out_pin_oe_n, parity_inhibit, tx_ninth_en, tx_ninth_bit;
    logic rx_ninth_en, data_word9, frac_baud_sel, net_irq;
    logic [8:0] rx_char, send_char = 9'h000;
    logic [2:0] frac_mult;
    logic [10:0] frac_numer;
    logic [3:0] p, q;
    int error_cnt = 0;
    int checks = 0;
    logic [15:0] fv [4] = '{16'hFFFF, 16'h0801, 16'h1000, 16'h8000};
    logic [7:0] nv [6] = '{8'h7F, 8'hE7, 8'hE6, 8'hC5, 8'h88, 8'hA0};
    logic [3:0] pv [7] = '{4'h8, 4'hC, 4'h8, 4'hA, 4'h8, 4'h9, 4'h1};
    logic [7:0] mc [6] = '{8'hB6, 8'hB6, 8'hB6, 8'hA6, 8'hB4, 8'h36};
    logic [8:0] mch [6] = '{9'h13C, 9'h1AA, 9'h03C, 9'h13C, 9'h03C, 9'h13C};
    logic [7:0] mid [6] = '{8'h0C, 8'h01, 8'h01, 8'h0C, 8'h0C, 8'h01};
    logic mirq [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

    unx_ext i_unx_ext (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dcd_pin(dcd_pin), .ri_pin(ri_pin),
        .dsr_pin(dsr_pin), .cts_pin(cts_pin), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
        .rx_buf_read(rx_buf_read), .tx_load(tx_load), .tx_char_done(tx_char_done), .tx_serial(tx_serial),
        .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe_n(serial_out_pin_oe_n),
        .parity_inhibit(parity_inhibit), .tx_ninth_en(tx_ninth_en), .tx_ninth_bit(tx_ninth_bit),
        .rx_ninth_en(rx_ninth_en), .data_word9(data_word9), .frac_baud_sel(frac_baud_sel),
        .frac_mult(frac_mult), .frac_numer(frac_numer), .net_irq(net_irq));

    unx_node_model i_unx_node_model (.core_clk(core_clk), .send_req(send_req), .send_char(send_char),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char));

    initial
    begin
        forever #20 core_clk = ~core_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    // Pulse select: buffer read, transmit load, transmit done
    task automatic pls(input logic [2:0] m);
        @(posedge core_clk);
        {rx_buf_read, tx_load, tx_char_done} <= m;
        @(posedge core_clk);
        {rx_buf_read, tx_load, tx_char_done} <= 3'b000;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic test_done;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        test_done();
    end

    initial
    begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        rchk(`UNX_OFF_MODEM, 16'h0000);
        rchk(`UNX_OFF_SCRATCH, 16'h0000);
        rchk(`UNX_OFF_NETCTL, 16'h0004);
        rchk(`UNX_OFF_IRQID, 16'h0001);
        rchk(`UNX_OFF_NODEADR, 16'h00AA);
        rchk(`UNX_OFF_FRACDIV, 16'h0000);
        chk(16'(frac_mult), 16'h0004);
        wr(32'hFFFF0730, 16'h00FF);
        rchk(32'hFFFF0730, 16'h0000);
        $display("test reset and map done");
        for (int i = 0; i < 4; i++)
        begin
            wr(`UNX_OFF_FRACDIV, fv[i]);
            rchk(`UNX_OFF_FRACDIV, fv[i] & 16'h9FFF);
            chk(16'(frac_baud_sel), 16'(fv[i][15]));
            chk(16'(frac_mult), (fv[i][12:11] == 2'd0) ? 16'h0004 : 16'(fv[i][12:11]));
            chk(16'(frac_numer), 16'(fv[i][10:0]));
        end
        $display("test fractional divider done");
        for (int i = 0; i < 6; i++)
        begin
            v = 16'(nv[i]);
            tx_serial <= v[0];
            wr(`UNX_OFF_NETCTL, v);
            wr(`UNX_OFF_SCRATCH, v ^ 16'h005A);
            rchk(`UNX_OFF_NETCTL, v);
            rchk(`UNX_OFF_SCRATCH, v ^ 16'h005A);
            chk(16'(parity_inhibit), 16'(v[7]));
            chk(16'(tx_ninth_en), 16'(v[7] & v[6]));
            chk(16'(rx_ninth_en), 16'(v[7] & v[5]));
            chk(16'(serial_out_pin_oe_n), 16'(v[7] & ~v[2]));
            chk(16'(serial_out_pin_o), 16'(v[0]));
            if (v[7] & v[6])
                chk(16'(tx_ninth_bit), {15'h0, ~(v[0] ^ v[1])});
            if (v[7])
                chk(16'(data_word9), 16'(v[3]));
        end
        // Write then read with no gap between the strobes
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= `UNX_OFF_SCRATCH;
        reg_wdata <= 16'h00C3;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, 16'h00C3);
        $display("test network controls done");
        wr(`UNX_OFF_NODEADR, 16'h003C);
        for (int i = 0; i < 6; i++)
        begin
            wr(`UNX_OFF_NETCTL, 16'(mc[i]));
            @(posedge core_clk);
            send_req <= 1'b1;
            send_char <= mch[i];
            @(posedge core_clk);
            send_req <= 1'b0;
            repeat (4) @(posedge core_clk);
            rchk(`UNX_OFF_IRQID, 16'(mid[i]));
            chk(16'(net_irq), 16'(mirq[i] == mc[i][1]));
            pls(3'b100);
            rchk(`UNX_OFF_IRQID, 16'h0001);
        end
        $display("test address match done");
        wr(`UNX_OFF_NETCTL, 16'h00E7);
        pls(3'b010);
        pls(3'b001);
        rchk(`UNX_OFF_IRQID, 16'h000A);
        wr(`UNX_OFF_NETCTL, 16'h00E6);
        // Ninth bit output is registered behind the control register
        repeat (2) @(posedge core_clk);
        #1 chk(16'(tx_ninth_bit), 16'h0000);
        pls(3'b010);
        rchk(`UNX_OFF_IRQID, 16'h0001);
        $display("test address transmit done");
        q = 4'h0;
        for (int i = 0; i < 7; i++)
        begin
            p = pv[i];
            {dcd_pin, ri_pin, dsr_pin, cts_pin} <= p;
            repeat (8) @(posedge core_clk);
            rchk(`UNX_OFF_MODEM, {8'h00, p, p[3] ^ q[3], p[2] & ~q[2], p[1:0] ^ q[1:0]});
            rchk(`UNX_OFF_MODEM, {8'h00, p, 4'h0});
            q = p;
        end
        for (int d = 0; d < 6; d++)
        begin
            cts_pin <= ~cts_pin;
            dcd_pin <= ~dcd_pin;
            repeat (d) @(posedge core_clk);
            rd(`UNX_OFF_MODEM, r1);
            repeat (8) @(posedge core_clk);
            rd(`UNX_OFF_MODEM, r2);
            chk(16'(r1[0] ^ r2[0]), 16'h0001);
            chk(16'(r1[3] ^ r2[3]), 16'h0001);
        end
        $display("test modem status done");
        test_done();
    end
endmodule

`default_nettype wire
